// *** core/sector_cmd.v ***
/*
 * Device-side command interpreter for sector read, read-verify and
 * password-disable. Holds the command block registers and the status.
 * Assumes a media engine that answers one sector request per sector
 * with a done pulse and error flags, all on REF_CLK.
 */
// The register addresses and the strobed register port were chosen for this implementation.
`timescale 1ns/1ns
`include "sector_cmd_map.vh"

module sector_cmd #(
    parameter PACKET_SET   = 0,
    parameter SECURITY_SET = 1,
    parameter REMOVABLE    = 1,
    parameter MAX_BLOCK    = 28'h0ffffff
) (
    input  wire        REF_CLK,
    input  wire        RST,
    input  wire [2:0]  ADDR,
    input  wire [15:0] WDATA,
    input  wire        WR,
    input  wire        RD,
    output reg  [15:0] RDATA,
    output reg  [27:0] MEDIA_ADDR,
    output reg         MEDIA_BLOCK_MODE,
    output reg         MEDIA_REQ,
    input  wire        MEDIA_DONE,
    input  wire        MEDIA_UNC,
    input  wire        MEDIA_NOT_FOUND,
    input  wire        MEDIA_FAULT,
    input  wire        MEDIA_CRC_ERR,
    input  wire        MEDIA_CHANGED,
    input  wire        MEDIA_CHANGE_REQ,
    input  wire        MEDIA_ABSENT,
    input  wire        XLATE_VALID,
    input  wire        SECURITY_LOCKED,
    input  wire        SECURITY_FROZEN,
    input  wire [15:0] PASSWORD_WORD,
    output reg  [3:0]  PASSWORD_ADDR,
    input  wire        MASTER_PW_MATCH_OK,
    output reg         UNLOCK,
    output reg         SECTOR_WORD_VALID,
    output reg         COMPARE_MASTER
);

// ========================================================================
// States
localparam S_IDLE    = 3'h0;
localparam S_SEEK    = 3'h1;
localparam S_DRQ_IN  = 3'h2;
localparam S_DRQ_OUT = 3'h3;
localparam S_CHECK   = 3'h4;

reg [2:0]  state_reg;
reg [7:0]  sect_count_reg;
reg [7:0]  sect_num_reg;
reg [7:0]  cyl_low_reg;
reg [7:0]  cyl_high_reg;
reg [7:0]  dev_head_reg;
reg [7:0]  error_reg;
reg [7:0]  status_reg;
reg [8:0]  remain_reg;
reg [8:0]  word_cnt_reg;
reg        verify_reg;
reg        media_change_seen_reg;
reg        change_req_reg;
reg        pw_ok_reg;
reg        pw_master_reg;
reg [15:0] data_reg;

// Both modes carry 28 address bits; CYL_HEAD_SECTOR_ADDRESSING packs cyl/head/sector the same way
function [27:0] start_address;
    input [7:0] dh;
    input [7:0] ch;
    input [7:0] cl;
    input [7:0] sn;
    begin
        start_address = {dh[3:0], ch, cl, sn};
    end
endfunction

function [8:0] sector_total;
    input [7:0] cnt;
    begin
        sector_total = (cnt == 8'h00) ? 9'h100 : {1'b0, cnt};
    end
endfunction

wire [27:0] cur_addr = start_address(dev_head_reg, cyl_high_reg,
                                     cyl_low_reg, sect_num_reg);
wire [27:0] next_addr = cur_addr + 28'h1;
wire        range_bad = (cur_addr > MAX_BLOCK);

// ========================================================================
// Register writes, command dispatch and sequencing
always @(posedge REF_CLK) begin
    if (RST) begin
        state_reg             <= S_IDLE;
        sect_count_reg        <= 8'h01;
        sect_num_reg          <= 8'h01;
        cyl_low_reg           <= 8'h00;
        cyl_high_reg          <= 8'h00;
        dev_head_reg          <= 8'h00;
        error_reg             <= 8'h00;
        status_reg            <= `STATUS_RESET;
        remain_reg            <= 9'h000;
        word_cnt_reg          <= 9'h000;
        verify_reg            <= 1'b0;
        media_change_seen_reg <= 1'b0;
        change_req_reg        <= 1'b0;
        pw_ok_reg             <= 1'b0;
        pw_master_reg         <= 1'b0;
        data_reg              <= 16'h0000;
        MEDIA_ADDR            <= 28'h0000000;
        MEDIA_BLOCK_MODE      <= 1'b0;
        MEDIA_REQ             <= 1'b0;
        PASSWORD_ADDR         <= 4'h0;
        UNLOCK                <= 1'b0;
        SECTOR_WORD_VALID     <= 1'b0;
        COMPARE_MASTER        <= 1'b0;
    end else begin
        MEDIA_REQ         <= 1'b0;
        UNLOCK            <= 1'b0;
        SECTOR_WORD_VALID <= 1'b0;
        // Latched event wins over the consuming command in the same cycle
        if (MEDIA_CHANGED)
            media_change_seen_reg <= 1'b1;
        if (MEDIA_CHANGE_REQ)
            change_req_reg <= 1'b1;
        // Taskfile writes ignored while busy, as hosts must not write then
        if (WR && !status_reg[`ST_BUSY]) begin
            if (ADDR == `IDX_SECT_COUNT) begin
                sect_count_reg <= WDATA[7:0];
            end else if (ADDR == `IDX_SECT_NUM) begin
                sect_num_reg <= WDATA[7:0];
            end else if (ADDR == `IDX_CYL_LOW) begin
                cyl_low_reg <= WDATA[7:0];
            end else if (ADDR == `IDX_CYL_HIGH) begin
                cyl_high_reg <= WDATA[7:0];
            end else if (ADDR == `IDX_DEV_HEAD) begin
                dev_head_reg <= WDATA[7:0];
            end else if (ADDR == `IDX_CMD_STATUS) begin
                error_reg  <= 8'h00;
                status_reg <= 8'h80;
                verify_reg <= (WDATA[7:0] == `OP_READ_VERIFY);
                remain_reg <= sector_total(sect_count_reg);
                // Stale word count would fake an end of password sector
                word_cnt_reg <= 9'h000;
                if (WDATA[7:0] == `OP_READ_SECTORS ||
                    (WDATA[7:0] == `OP_READ_VERIFY && PACKET_SET == 0)) begin
                    state_reg <= S_SEEK;
                end else if (WDATA[7:0] == `OP_PW_DISABLE && SECURITY_SET != 0
                             && !SECURITY_LOCKED && !SECURITY_FROZEN) begin
                    // Sector count, address and drive select are not used here
                    word_cnt_reg  <= 9'h000;
                    pw_ok_reg     <= 1'b1;
                    status_reg    <= 8'h48;
                    state_reg     <= S_DRQ_OUT;
                end else begin
                    if (WDATA[7:0] == `OP_MEDIA_QUERY)
                        change_req_reg <= MEDIA_CHANGE_REQ;
                    error_reg  <= 8'h04;
                    status_reg <= 8'h41;
                end
            end
        end
        if (WR && ADDR == `IDX_DATA && state_reg == S_DRQ_OUT) begin
            // Word 0 picks the password; words 1-16 are compared
            SECTOR_WORD_VALID <= 1'b1;
            if (word_cnt_reg == 9'h000) begin
                pw_master_reg  <= WDATA[0];
                COMPARE_MASTER <= WDATA[0];
                PASSWORD_ADDR  <= 4'h0;
            end else if (word_cnt_reg <= 9'h010) begin
                // Address runs one word ahead so the store has settled
                PASSWORD_ADDR <= word_cnt_reg[3:0];
                if (WDATA != PASSWORD_WORD)
                    pw_ok_reg <= 1'b0;
            end
            word_cnt_reg <= word_cnt_reg + 9'h001;
            if (word_cnt_reg == `WORDS_PER_SECTOR - 9'h001)
                state_reg <= S_CHECK;
        end
        if (RD && ADDR == `IDX_DATA && state_reg == S_DRQ_IN) begin
            word_cnt_reg <= word_cnt_reg + 9'h001;
            if (word_cnt_reg == `WORDS_PER_SECTOR - 9'h001) begin
                word_cnt_reg <= 9'h000;
                status_reg <= 8'h80;
                state_reg  <= S_SEEK;
            end
        end
        case (state_reg)
        S_SEEK: begin
            if (!MEDIA_REQ && status_reg[`ST_BUSY]) begin
                MEDIA_ADDR       <= cur_addr;
                MEDIA_BLOCK_MODE <= dev_head_reg[`DH_BLOCK_BIT];
                if (remain_reg == 9'h000) begin
                    status_reg <= 8'h40;
                    state_reg  <= S_IDLE;
                end else if (REMOVABLE != 0 &&
                             (MEDIA_ABSENT || media_change_seen_reg)) begin
                    error_reg[`ER_NM] <= MEDIA_ABSENT;
                    error_reg[`ER_MC] <= media_change_seen_reg;
                    error_reg[`ER_MCR] <= change_req_reg;
                    media_change_seen_reg <= MEDIA_CHANGED;
                    status_reg <= 8'h41;
                    state_reg  <= S_IDLE;
                end else if (range_bad || !XLATE_VALID &&
                             !dev_head_reg[`DH_BLOCK_BIT]) begin
                    error_reg  <= 8'h10;
                    status_reg <= 8'h41;
                    state_reg  <= S_IDLE;
                end else begin
                    MEDIA_REQ <= 1'b1;
                    change_req_reg <= MEDIA_CHANGE_REQ;
                    state_reg <= S_CHECK;
                end
            end
        end
        S_CHECK: begin
            if (verify_reg || !pw_ok_reg || remain_reg != 9'h000 ||
                word_cnt_reg != 9'h000) begin
                if (word_cnt_reg == `WORDS_PER_SECTOR) begin
                    // End of password sector
                    UNLOCK     <= pw_ok_reg && (!pw_master_reg ||
                                  MASTER_PW_MATCH_OK);
                    error_reg  <= pw_ok_reg ? 8'h00 : 8'h04;
                    status_reg <= pw_ok_reg ? 8'h40 : 8'h41;
                    word_cnt_reg <= 9'h000;
                    state_reg  <= S_IDLE;
                end else if (MEDIA_DONE) begin
                    if (MEDIA_UNC || MEDIA_NOT_FOUND || MEDIA_FAULT ||
                        MEDIA_CRC_ERR) begin
                        // Failing address left in the taskfile
                        error_reg[`ER_UNC]  <= MEDIA_UNC;
                        error_reg[`ER_ADDRESS_NOT_FOUND_BIT] <= MEDIA_NOT_FOUND;
                        error_reg[`ER_COMMAND_ABORTED_BIT] <= MEDIA_CRC_ERR;
                        error_reg[`ER_MCR]  <= change_req_reg;
                        status_reg <= {3'b010, 1'b0, 3'b000, 1'b0} |
                                      {2'b00, MEDIA_FAULT, 4'h0,
                                       !MEDIA_FAULT || MEDIA_UNC ||
                                       MEDIA_NOT_FOUND || MEDIA_CRC_ERR};
                        state_reg <= S_IDLE;
                    end else begin
                        remain_reg <= remain_reg - 9'h001;
                        {dev_head_reg[3:0], cyl_high_reg, cyl_low_reg,
                         sect_num_reg} <= next_addr;
                        word_cnt_reg <= 9'h000;
                        if (verify_reg) begin
                            state_reg <= S_SEEK;
                        end else begin
                            status_reg <= 8'h48;
                            state_reg  <= S_DRQ_IN;
                        end
                    end
                end
            end else begin
                status_reg <= 8'h40;
                state_reg  <= S_IDLE;
            end
        end
        default: begin
        end
        endcase
        if (!status_reg[`ST_BUSY] && !status_reg[`ST_DRQ])
            status_reg[`ST_READY] <= 1'b1;
    end
end

// ========================================================================
// Read port: data one cycle after the strobe
always @(posedge REF_CLK) begin
    if (RST) begin
        RDATA <= 16'h0000;
    end else if (RD) begin
        if (ADDR == `IDX_FEAT_ERR)
            RDATA <= {8'h00, error_reg};
        else if (ADDR == `IDX_SECT_COUNT)
            RDATA <= {8'h00, sect_count_reg};
        else if (ADDR == `IDX_SECT_NUM)
            RDATA <= {8'h00, sect_num_reg};
        else if (ADDR == `IDX_CYL_LOW)
            RDATA <= {8'h00, cyl_low_reg};
        else if (ADDR == `IDX_CYL_HIGH)
            RDATA <= {8'h00, cyl_high_reg};
        else if (ADDR == `IDX_DEV_HEAD)
            RDATA <= {8'h00, dev_head_reg};
        else if (ADDR == `IDX_CMD_STATUS)
            RDATA <= {8'h00, status_reg};
        else
            RDATA <= {cur_addr[15:0] ^ {7'h00, word_cnt_reg}}; // Test pattern
    end else begin
        RDATA <= 16'h0000;
    end
end

endmodule

// *** core/sector_cmd_map.vh ***
/*
 * Register indices, field positions, opcodes and reset values for the
 * sector read / read-verify command interpreter.
 * Assumes a plain register port with indices 0..7 and 16-bit data.
 */
`ifndef SECTOR_CMD_MAP_VH
`define SECTOR_CMD_MAP_VH

// ========================================================================
// Register indices
`define IDX_FEAT_ERR       3'h1
`define IDX_SECT_COUNT     3'h2
`define IDX_SECT_NUM       3'h3
`define IDX_CYL_LOW        3'h4
`define IDX_CYL_HIGH       3'h5
`define IDX_DEV_HEAD       3'h6
`define IDX_CMD_STATUS     3'h7
`define IDX_DATA           3'h0

// ========================================================================
// Opcodes
`define OP_READ_SECTORS    8'h20
`define OP_READ_VERIFY     8'h40
`define OP_PW_DISABLE      8'hf6
`define OP_MEDIA_QUERY     8'hda

// ========================================================================
// Field positions
`define DH_BLOCK_BIT       6
`define DH_DEV_BIT         4
`define ST_BUSY            7
`define ST_READY           6
`define ST_FAULT           5
`define ST_DRQ             3
`define ST_ERR             0
`define ER_UNC             6
`define ER_MC              5
`define ER_ADDRESS_NOT_FOUND_BIT            4
`define ER_MCR             3
`define ER_COMMAND_ABORTED_BIT            2
`define ER_NM              1

// ========================================================================
// Reset values and timing
`define STATUS_RESET       8'h40
`define WORDS_PER_SECTOR   9'h100
`define SECTOR_TIME_NS     1000
`define CLK_PERIOD_NS      10
`define SECTOR_CYCLES      (`SECTOR_TIME_NS / `CLK_PERIOD_NS)

`endif

// *** tb/sector_cmd_props.sv ***
/*
 * Port checker for the sector command interpreter.
 * Assumes one clock REF_CLK and a synchronous active-high RST.
 */
`timescale 1ns/1ns
module sector_cmd_props (
    input wire        REF_CLK,
    input wire        RST,
    input wire [2:0]  ADDR,
    input wire [15:0] WDATA,
    input wire        WR,
    input wire        RD,
    input wire [15:0] RDATA,
    input wire [27:0] MEDIA_ADDR,
    input wire        MEDIA_BLOCK_MODE,
    input wire        MEDIA_REQ,
    input wire        MEDIA_DONE,
    input wire        UNLOCK,
    input wire        SECTOR_WORD_VALID,
    input wire        COMPARE_MASTER
);
    default clocking @(posedge REF_CLK); endclocking
    default disable iff (RST);
    // ======================================================
    // Sector request outstanding at the media side
    reg out_reg;
    always @(posedge REF_CLK) begin
        if (RST)
            out_reg <= 1'b0;
        else if (MEDIA_REQ)
            out_reg <= 1'b1;
        else if (MEDIA_DONE)
            out_reg <= 1'b0;
    end
    rdata_idle_a: assert property (!$past(RD) |->
        RDATA == 16'h0000)
        else $error("read data not zero outside read");
    req_pulse_a: assert property (MEDIA_REQ |=> !MEDIA_REQ)
        else $error("sector request longer than one cycle");
    req_single_a: assert property (MEDIA_REQ |-> !out_reg)
        else $error("sector request while one is outstanding");
    addr_hold_a: assert property (out_reg |-> $stable(MEDIA_ADDR))
        else $error("sector address moved during request");
    mode_hold_a: assert property (out_reg |->
        $stable(MEDIA_BLOCK_MODE))
        else $error("addressing mode moved during request");
    unlock_pulse_a: assert property (UNLOCK |=> !UNLOCK)
        else $error("unlock longer than one cycle");
    word_valid_a: assert property (SECTOR_WORD_VALID |->
        $past(WR) && $past(ADDR) == 3'h0)
        else $error("word strobe without data write");
    master_sel_a: assert property ($changed(COMPARE_MASTER) |->
        $past(WR) && $past(ADDR) == 3'h0
        && $past(WDATA[0]) == COMPARE_MASTER)
        else $error("password select not from word bit 0");
endmodule
bind sector_cmd sector_cmd_props i_props (.REF_CLK(REF_CLK), .RST(RST),
    .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD), .RDATA(RDATA),
    .MEDIA_ADDR(MEDIA_ADDR), .MEDIA_BLOCK_MODE(MEDIA_BLOCK_MODE),
    .MEDIA_REQ(MEDIA_REQ), .MEDIA_DONE(MEDIA_DONE), .UNLOCK(UNLOCK),
    .SECTOR_WORD_VALID(SECTOR_WORD_VALID), .COMPARE_MASTER(COMPARE_MASTER));

// *** tb/media_model.sv ***
/*
 * Media engine model: one done pulse per sector request, prompt or slow,
 * with error flags on one chosen sector. Assumes the REF_CLK domain.
 */
`timescale 1ns/1ns
module media_model (
    input  wire        ref_clk,
    input  wire        rst,
    input  wire        req,
    input  wire [27:0] addr,
    input  wire        slow,
    input  wire [27:0] fail_addr,
    input  wire [3:0]  fail_kind,
    output reg         done,
    output wire [3:0]  flags
);
    reg [4:0] wait_reg;
    reg       busy_reg;
    reg [3:0] hit_reg;
    // Flags are junk outside done so the design must sample them with it
    assign flags = done ? hit_reg : ~hit_reg;
    always @(posedge ref_clk) begin
        done <= 1'b0;
        if (rst) begin
            busy_reg <= 1'b0;
            hit_reg <= 4'h0;
        end else if (req) begin
            busy_reg <= 1'b1;
            wait_reg <= slow ? 5'h14 : 5'h00;
            hit_reg <= (addr == fail_addr) ? fail_kind : 4'h0;
        end else if (busy_reg) begin
            if (wait_reg == 5'h00) begin
                done <= 1'b1;
                busy_reg <= 1'b0;
            end else
                wait_reg <= wait_reg - 5'h01;
        end
    end
endmodule

// *** tb/tb.sv ***
/*
 * Self-checking bench for the sector command interpreter.
 * Assumes the media model on the far side and a 100 MHz REF_CLK.
 */
`timescale 1ns/1ns
`include "sector_cmd_map.vh"
module tb;
    logic        REF_CLK = 0, RST = 1, WR = 0, RD = 0;
    logic        slow = 0, chg = 0, absent = 0, frozen = 0, locked = 0;
    logic        xlate = 1;
    logic [2:0]  ADDR = 0;
    logic [15:0] WDATA = 0;
    logic [27:0] fail_addr = '1, a, first_addr;
    logic [3:0]  fail_kind = 0, fl;
    logic [7:0]  st, d;
    logic [7:0]  rst_v [1:7] = '{8'h00, 8'h01, 8'h01, 0, 0, 0, 8'h40};
    logic [7:0]  err_m [0:3] = '{8'h40, 8'h10, 8'h00, 8'h04};
    wire  [15:0] RDATA;
    wire  [27:0] maddr;
    wire  [3:0]  pw_a;
    wire         blk, req, done, unl, wv, mst;
    int          err_total = 0, checked = 0, nreq = 0, nunl = 0, drq_n, k;
    sector_cmd i_dut (.REF_CLK(REF_CLK), .RST(RST), .ADDR(ADDR),
        .WDATA(WDATA), .WR(WR), .RD(RD), .RDATA(RDATA), .MEDIA_ADDR(maddr),
        .MEDIA_BLOCK_MODE(blk), .MEDIA_REQ(req), .MEDIA_DONE(done),
        .MEDIA_UNC(fl[0]), .MEDIA_NOT_FOUND(fl[1]), .MEDIA_FAULT(fl[2]),
        .MEDIA_CRC_ERR(fl[3]), .MEDIA_CHANGED(chg), .MEDIA_CHANGE_REQ(chg),
        .MEDIA_ABSENT(absent), .XLATE_VALID(xlate), .SECURITY_LOCKED(locked),
        .SECURITY_FROZEN(frozen), .PASSWORD_WORD(16'h5a5a),
        .PASSWORD_ADDR(pw_a), .MASTER_PW_MATCH_OK(1'b1), .UNLOCK(unl),
        .SECTOR_WORD_VALID(wv), .COMPARE_MASTER(mst));
    media_model i_media (.ref_clk(REF_CLK), .rst(RST), .req(req),
        .addr(maddr), .slow(slow), .fail_addr(fail_addr),
        .fail_kind(fail_kind), .done(done), .flags(fl));
    initial forever #5 REF_CLK = ~REF_CLK;
    always @(posedge REF_CLK) begin
        if (req && nreq == 0)
            first_addr <= maddr;
        nreq <= nreq + int'(req);
        nunl <= nunl + int'(unl);
    end
    // Error summary follows the error byte; a bare fault leaves it clear
    function logic [7:0] exp_st(input logic f, input logic [7:0] e);
        exp_st = {2'b01, f, 4'h0, |e};
    endfunction
    task chk(input logic [27:0] g, e);
        checked++;
        if (g !== e) begin
            err_total++;
            $display("wrong value at %0t: got %h expected %h", $time, g, e);
        end
    endtask
    task wr(input logic [2:0] ad, input logic [15:0] v);
        @(posedge REF_CLK);
        ADDR <= ad;
        WDATA <= v;
        WR <= 1'b1;
        @(posedge REF_CLK);
        WR <= 1'b0;
    endtask
    task rd(input logic [2:0] ad);
        @(posedge REF_CLK);
        ADDR <= ad;
        RD <= 1'b1;
        @(posedge REF_CLK);
        RD <= 1'b0;
        #1 d = RDATA[7:0];
    endtask
    task rchk(input logic [2:0] ad, input logic [7:0] m, e);
        rd(ad);
        chk(28'(d & m), 28'(e));
    endtask
    // ======================================================
    // Whole command: parameters, opcode, then poll and move data
    task cmd(input logic [7:0] op, cnt, input logic block_addressing);
        int i, n;
        nreq = 0;
        drq_n = 0;
        wr(3'h2, {8'h00, cnt});
        wr(3'h3, {8'h00, a[7:0]});
        wr(3'h4, {8'h00, a[15:8]});
        wr(3'h5, {8'h00, a[23:16]});
        wr(3'h6, {8'h00, 1'b1, block_addressing, 1'b1, a[0], a[27:24]});
        rchk(3'h7, 8'h40, 8'h40);
        wr(3'h7, {8'h00, op});
        for (n = 0; n < 20000; n++) begin
            rd(3'h7);
            st = d;
            if (st[3]) begin
                drq_n++;
                for (i = 0; i < 256; i++)
                    if (op == `OP_PW_DISABLE)
                        wr(3'h0, i == 0 ? 16'h0001 :
                                 i < 17 ? 16'h5a5a : 16'h0000);
                    else
                        rd(3'h0);
            end else if (!st[7])
                break;
        end
        chk(28'(n < 20000), 28'h1);
    endtask
    task conclude;
        $display("checked %0d err_total %0d", checked, err_total);
        if (err_total == 0 && checked > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    initial begin
        #900000;
        err_total++;
        conclude;
    end
    initial begin
        k = $urandom(82243);
        repeat (3) @(posedge REF_CLK);
        RST <= 1'b0;
        for (k = 1; k < 8; k++)
            rchk(k[2:0], 8'hff, rst_v[k]);
        a = $urandom_range(28'h0fffe00);
        slow <= 1'($urandom);
        cmd(`OP_READ_VERIFY, 8'h00, 1'b1);
        chk(28'(st), 28'h40);
        chk(28'(nreq), 28'd256);
        chk(first_addr, a);
        chk(28'(drq_n | blk), 28'h1);
        a = 28'h0000101;
        k = $urandom_range(8, 1);
        cmd(`OP_READ_VERIFY, 8'(k), 1'b0);
        chk(28'({nreq[7:0], blk}), 28'({8'(k), 1'b0}));
        a = $urandom_range(28'h0fffe00);
        cmd(`OP_READ_SECTORS, 8'h02, 1'b1);
        chk(28'({drq_n[3:0], nreq[3:0], st}), 28'h22_40);
        $display("test verify and read done");
        for (k = 0; k < 4; k++) begin
            a = $urandom_range(28'h0fffe00);
            fail_addr = a + 28'h2;
            fail_kind = 4'h1 << k;
            slow <= k[0];
            cmd(`OP_READ_VERIFY, 8'h05, 1'b1);
            chk(28'(st), 28'(exp_st(k == 2, err_m[k])));
            chk(28'(nreq), 28'h3);
            rchk(3'h1, err_m[k], err_m[k]);
            rchk(3'h3, 8'hff, fail_addr[7:0]);
            rchk(3'h5, 8'hff, fail_addr[23:16]);
            rchk(3'h6, 8'h1f, {a[0], fail_addr[27:24]});
        end
        fail_kind = 4'h0;
        a = 28'h1000000;
        cmd(`OP_READ_VERIFY, 8'h01, 1'b1);
        rd(3'h1);
        chk(28'({d[4] ^ d[2], st[0]}), 28'h3);
        a = 28'h0000040;
        @(posedge REF_CLK);
        chg <= 1'b1;
        @(posedge REF_CLK);
        chg <= 1'b0;
        cmd(`OP_READ_VERIFY, 8'h01, 1'b1);
        rchk(3'h1, 8'h28, 8'h28);
        cmd(`OP_READ_VERIFY, 8'h01, 1'b1);
        chk(28'(st), 28'h40);
        absent <= 1'b1;
        cmd(`OP_READ_VERIFY, 8'h01, 1'b1);
        rchk(3'h1, 8'h02, 8'h02);
        absent <= 1'b0;
        xlate <= 1'b0;
        cmd(`OP_READ_VERIFY, 8'h01, 1'b0);
        rchk(3'h1, 8'hff, 8'h10);
        xlate <= 1'b1;
        $display("test errors done");
        cmd(8'h55, 8'h01, 1'b1);
        rchk(3'h1, 8'hff, 8'h04);
        chk(28'({nreq[3:0], st}), 28'h041);
        for (k = 0; k < 2; k++) begin
            {locked, frozen} <= 2'b01 << k;
            cmd(`OP_PW_DISABLE, 8'h00, 1'b0);
            chk(28'({drq_n[3:0], nunl[3:0], st}), 28'h0041);
        end
        {locked, frozen} <= 2'b00;
        cmd(`OP_PW_DISABLE, 8'h00, 1'b0);
        chk(28'({drq_n[3:0], nunl[3:0], st}), 28'h1140);
        $display("test security done");
        conclude;
    end
endmodule
